// >>> verilog/scs_device.sv
`timescale 1ns/10ps
// strap capture, clock select and bus decode of the graphics controller
module scs_device
#(
    parameter int MEM_KB      = scs_pkg::MEM_KB_DEFAULT,
    parameter int REFRESH_CYC = scs_pkg::REFRESH_CYC
)
(
    scs_if.device           bus,
    output logic [1:0]      dot_clk_sel,
    output logic            bus_is_isa,
    output logic            aux_clk_outputs,
    output logic            dram_refresh_req,
    output logic [7:0]      misc_output_clock_select,
    output logic            mem_size_ok
);
    logic [7:0]  strap_sync1;
    logic [7:0]  strap_sync2;
    logic        strap_done;
    logic [7:0]  straps;
    logic [1:0]  rom_strap_config;
    logic [7:0]  power_up_strap_config;
    logic [7:0]  second_extended_control;
    logic        io_wr_prev;
    logic        misc_wr;
    logic        video_hit;
    logic        rom_hit;
    logic        pal_hit;
    logic        io_hit;
    logic        mem_cycle;
    logic [15:0] refresh_cnt;
    logic [7:0]  next_rdata;
    logic [1:0]  next_dot_sel;

    // strap pins cross into the clock domain through two flops
    always_ff @(posedge bus.sys_clk)
    begin
        strap_sync1 <= bus.video_memory_data_pins;
        strap_sync2 <= strap_sync1;
    end

    // selective inversion of the strap levels
    assign straps = strap_sync2 ^ scs_pkg::STRAP_INV_MASK;

    // capture once on the first edge after reset release, then hold
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
        begin
            strap_done            <= 1'b0;
            rom_strap_config      <= 2'h0;
            power_up_strap_config <= 8'h00;
        end
        else if (!strap_done)
        begin
            strap_done            <= 1'b1;
            rom_strap_config      <= straps[1:0];
            power_up_strap_config <= {straps[7:2], 2'h0};
        end
    end

    // mode bits seen by the rest of the block
    assign bus_is_isa      = power_up_strap_config[scs_pkg::BUS_SEL_BIT];
    assign aux_clk_outputs = power_up_strap_config[scs_pkg::CLK_DIR_BIT];

    // address decode of video memory, BIOS ROM and palette ports
    always_comb
    begin
        video_hit = bus.addr[19:17] == scs_pkg::VIDEO_MEM_TOP;
        rom_hit   = (bus.addr[19:15] == scs_pkg::BIOS_ROM_TOP)
                    && !rom_strap_config[scs_pkg::ROM_DECODE_BIT];
        pal_hit   = (bus.addr[15:0] >= scs_pkg::PAL_LO_ADDR)
                    && (bus.addr[15:0] <= scs_pkg::PAL_HI_ADDR);
        io_hit    = pal_hit
                    || bus.addr[15:0] == scs_pkg::MISC_ADDR
                    || bus.addr[15:0] == scs_pkg::ROM_CFG_ADDR
                    || bus.addr[15:0] == scs_pkg::SEC_CTRL_ADDR
                    || bus.addr[15:0] == scs_pkg::STATUS5_ADDR;
        mem_cycle = !bus.mem_rd_n || !bus.mem_wr_n;
    end

    // register writes take effect on the falling edge of the io write strobe
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
            io_wr_prev <= 1'b1;
        else
            io_wr_prev <= bus.io_wr_n;
    end

    assign misc_wr = io_wr_prev && !bus.io_wr_n && bus.addr[15:0] == scs_pkg::MISC_ADDR;

    // miscellaneous output register
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
            misc_output_clock_select <= scs_pkg::MISC_RESET;
        else if (misc_wr)
            misc_output_clock_select <= bus.wdata;
    end

    // second extended control register
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
            second_extended_control <= scs_pkg::SEC_CTRL_RESET;
        else if (io_wr_prev && !bus.io_wr_n
                 && bus.addr[15:0] == scs_pkg::SEC_CTRL_ADDR)
            second_extended_control <= bus.wdata;
    end

    // read mux; bus and clock strap bits are never visible
    always_comb
    begin
        next_rdata = 8'h00;
        case (bus.addr[15:0])
            scs_pkg::MISC_ADDR:     next_rdata = misc_output_clock_select;
            scs_pkg::ROM_CFG_ADDR:  next_rdata = {6'h00, rom_strap_config};
            scs_pkg::SEC_CTRL_ADDR: next_rdata = second_extended_control;
            scs_pkg::STATUS5_ADDR:  next_rdata = {power_up_strap_config[7:4], 4'h0};
            default:                next_rdata = 8'h00;
        endcase
    end

    // read data register, loaded while the read strobe is low
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
            bus.rdata <= 8'h00;
        else if (!bus.io_rd_n)
            bus.rdata <= next_rdata;
    end

    // dot clock multiplexer select
    always_comb
    begin
        if (aux_clk_outputs)
            next_dot_sel = scs_pkg::DOT_CLK_ZERO;
        else if (misc_output_clock_select[scs_pkg::MISC_SEL_HI])
            next_dot_sel = scs_pkg::DOT_CLK_TWO;
        else if (misc_output_clock_select[scs_pkg::MISC_SEL_LO])
            next_dot_sel = scs_pkg::DOT_CLK_ONE;
        else
            next_dot_sel = scs_pkg::DOT_CLK_ZERO;
    end

    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
            dot_clk_sel <= scs_pkg::DOT_CLK_ZERO;
        else
            dot_clk_sel <= next_dot_sel;
    end

    // auxiliary clock pins when they are outputs
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
        begin
            bus.aux_one_out <= 1'b1;
            bus.aux_two_out <= 1'b0;
        end
        else
        begin
            bus.aux_one_out <= !(misc_wr && aux_clk_outputs);
            bus.aux_two_out <= second_extended_control[scs_pkg::AUX_TWO_BIT];
        end
    end

    assign bus.aux_one_oe = aux_clk_outputs;
    assign bus.aux_two_oe = aux_clk_outputs;

    // bus side select, size and feedback outputs
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
        begin
            bus.card_feedback_out     <= 1'b1;
            bus.data_size_sixteen_out <= 1'b1;
            bus.bios_rom_enable_out   <= 1'b1;
            bus.data_buffer_enable_out <= 1'b1;
            bus.rom_width_indication  <= 1'b1;
        end
        else
        begin
            bus.rom_width_indication <= !rom_strap_config[scs_pkg::ROM_WIDTH_BIT];
            bus.bios_rom_enable_out  <= !(rom_hit && !bus.mem_rd_n);
            bus.data_buffer_enable_out <= !((video_hit && mem_cycle)
                                            || (io_hit && (!bus.io_rd_n || !bus.io_wr_n)));
            if (bus_is_isa)
            begin
                // static in ISA mode for external 16-bit select, low only when the ROM width strap bit is set
                bus.card_feedback_out     <= !rom_strap_config[scs_pkg::ROM_WIDTH_BIT];
                bus.data_size_sixteen_out <= !(video_hit && mem_cycle);
            end
            else
            begin
                bus.card_feedback_out     <= !((video_hit || rom_hit) && mem_cycle
                                               || io_hit && (!bus.io_rd_n || !bus.io_wr_n));
                bus.data_size_sixteen_out <= !(rom_strap_config[scs_pkg::ROM_WIDTH_BIT]
                                               && rom_hit);
            end
        end
    end

    // palette strobes for the external colour table
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
        begin
            bus.palette_write_strobe <= 1'b1;
            bus.palette_read_strobe  <= 1'b1;
        end
        else
        begin
            bus.palette_write_strobe <= !(pal_hit && !bus.io_wr_n);
            bus.palette_read_strobe  <= !(pal_hit && !bus.io_rd_n);
        end
    end

    // refresh request timer for the video memory controller
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
        begin
            refresh_cnt      <= 16'h0000;
            dram_refresh_req <= 1'b0;
        end
        else if (refresh_cnt == 16'(REFRESH_CYC - 1))
        begin
            refresh_cnt      <= 16'h0000;
            dram_refresh_req <= 1'b1;
        end
        else
        begin
            refresh_cnt      <= refresh_cnt + 16'h0001;
            dram_refresh_req <= 1'b0;
        end
    end

    // only the three array sizes of 64Kx4 parts are supported
    assign mem_size_ok = (MEM_KB == 256) || (MEM_KB == 512) || (MEM_KB == 1024);
endmodule

// >>> verilog/scs_pkg.sv
package scs_pkg;
    // i/o register addresses
    localparam logic [15:0] MISC_ADDR      = 16'h03c2;
    localparam logic [15:0] ROM_CFG_ADDR   = 16'h03e1;
    localparam logic [15:0] SEC_CTRL_ADDR  = 16'h03e2;
    localparam logic [15:0] STATUS5_ADDR   = 16'h03e5;
    localparam logic [15:0] PAL_LO_ADDR    = 16'h03c6;
    localparam logic [15:0] PAL_HI_ADDR    = 16'h03c9;
    // reset values
    localparam logic [7:0]  MISC_RESET     = 8'h00;
    localparam logic [7:0]  SEC_CTRL_RESET = 8'h00;
    // strap bit positions
    localparam int          ROM_DECODE_BIT = 0;
    localparam int          ROM_WIDTH_BIT  = 1;
    localparam int          BUS_SEL_BIT    = 2;
    localparam int          CLK_DIR_BIT    = 3;
    localparam logic [7:0]  STRAP_INV_MASK = 8'hf3;
    // field positions
    localparam int          MISC_SEL_LO    = 2;
    localparam int          MISC_SEL_HI    = 3;
    localparam int          AUX_TWO_BIT    = 1;
    // memory windows (upper address bits)
    localparam logic [2:0]  VIDEO_MEM_TOP  = 3'h5;
    localparam logic [4:0]  BIOS_ROM_TOP   = 5'h18;
    // dot clock selections
    localparam logic [1:0]  DOT_CLK_ZERO   = 2'h0;
    localparam logic [1:0]  DOT_CLK_ONE    = 2'h1;
    localparam logic [1:0]  DOT_CLK_TWO    = 2'h2;
    // timing
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          EXT_CYCLE_NS   = 300;
    localparam int          EXT_CYCLE_CYC  = (EXT_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          AT_CMD_CYC     = 2;
    localparam int          PAL_WAIT_CYC   = 2;
    localparam int          REFRESH_NS     = 15600;
    localparam int          REFRESH_CYC    = REFRESH_NS / CLK_PERIOD_NS;
    localparam int          MEM_KB_DEFAULT = 256;
endpackage

// >>> verilog/scs_if.sv
`timescale 1ns/10ps
// strap, host bus and clock pin signals between the system and the device
interface scs_if
(
    input wire logic sys_clk,
    input wire logic sys_rst
);
    logic [7:0]  video_memory_data_pins;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        mem_rd_n;
    logic        mem_wr_n;
    logic        io_rd_n;
    logic        io_wr_n;
    logic        byte_high_n;
    logic        bios_rom_enable_out;
    logic        data_buffer_enable_out;
    logic        card_feedback_out;
    logic        data_size_sixteen_out;
    logic        rom_width_indication;
    logic        palette_write_strobe;
    logic        palette_read_strobe;
    logic        aux_one_out;
    logic        aux_one_oe;
    logic        aux_two_out;
    logic        aux_two_oe;
    logic [1:0]  osc_level;
    logic        aux_clock_pin_one;
    logic        aux_clock_pin_two;

    // pin level: device drives while enabled, oscillators otherwise
    assign aux_clock_pin_one = aux_one_oe ? aux_one_out : osc_level[0];
    assign aux_clock_pin_two = aux_two_oe ? aux_two_out : osc_level[1];

    modport device
    (
        input  sys_clk, sys_rst, video_memory_data_pins, addr, wdata, mem_rd_n, mem_wr_n,
        input  io_rd_n, io_wr_n, byte_high_n, aux_clock_pin_one, aux_clock_pin_two,
        output rdata, bios_rom_enable_out, data_buffer_enable_out, card_feedback_out,
        output data_size_sixteen_out, rom_width_indication, palette_write_strobe,
        output palette_read_strobe, aux_one_out, aux_one_oe, aux_two_out, aux_two_oe
    );
    modport host
    (
        input  sys_clk, sys_rst, rdata, bios_rom_enable_out, data_buffer_enable_out,
        input  card_feedback_out, data_size_sixteen_out, rom_width_indication,
        input  palette_write_strobe, palette_read_strobe, aux_clock_pin_one,
        input  aux_clock_pin_two,
        output video_memory_data_pins, addr, wdata, mem_rd_n, mem_wr_n, io_rd_n,
        output io_wr_n, byte_high_n, osc_level
    );
endinterface

// >>> verilog/scs_host.sv
`timescale 1ns/10ps
// host glue: straps, bus cycles and external buffer and ROM decode
module scs_host
#(
    parameter logic [7:0] STRAP_LEVELS = 8'h0c
)
(
    scs_if.host             bus,
    input  wire logic       usr_start,
    input  wire logic [1:0] usr_kind,
    input  wire logic [19:0] usr_addr,
    input  wire logic [7:0] usr_wdata,
    input  wire logic       usr_byte_high,
    input  wire logic [1:0] usr_osc,
    output logic            usr_busy,
    output logic            usr_done,
    output logic [7:0]      usr_rdata,
    output logic            upper_buffer_gate,
    output logic            low_byte_rom_oe,
    output logic            high_byte_rom_oe,
    output logic            rom_buffer_gate
);
    typedef enum logic [1:0]
    {
        SCS_IDLE = 2'b00,
        SCS_CMD  = 2'b01,
        SCS_DONE = 2'b10
    } scs_state_t;

    scs_state_t  state;
    logic [3:0]  wait_cnt;
    logic [1:0]  kind;
    logic [3:0]  next_wait;
    logic        isa_mode;
    logic        strobe_on;

    assign bus.video_memory_data_pins = STRAP_LEVELS;
    assign bus.osc_level = usr_osc;
    assign isa_mode = STRAP_LEVELS[scs_pkg::BUS_SEL_BIT];
    assign usr_busy = state != SCS_IDLE;
    assign strobe_on = state == SCS_CMD;

    // command length: extended in channel mode, padded for palette ports in ISA mode
    always_comb
    begin
        if (!isa_mode)
            next_wait = 4'(scs_pkg::EXT_CYCLE_CYC);
        else if (usr_kind[1] && usr_addr[15:0] >= scs_pkg::PAL_LO_ADDR
                 && usr_addr[15:0] <= scs_pkg::PAL_HI_ADDR)
            next_wait = 4'(scs_pkg::AT_CMD_CYC + scs_pkg::PAL_WAIT_CYC);
        else
            next_wait = 4'(scs_pkg::AT_CMD_CYC);
    end

    // cycle sequencer; kind: bit1 io, bit0 write
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
        begin
            state     <= SCS_IDLE;
            wait_cnt  <= 4'h0;
            kind      <= 2'h0;
            bus.addr  <= 20'h00000;
            bus.wdata <= 8'h00;
            bus.byte_high_n <= 1'b1;
            usr_done  <= 1'b0;
            usr_rdata <= 8'h00;
        end
        else
        begin
            usr_done <= 1'b0;
            case (state)
                SCS_IDLE:
                begin
                    if (usr_start)
                    begin
                        state     <= SCS_CMD;
                        wait_cnt  <= next_wait;
                        kind      <= usr_kind;
                        bus.addr  <= usr_addr;
                        bus.wdata <= usr_wdata;
                        bus.byte_high_n <= !usr_byte_high;
                    end
                end
                SCS_CMD:
                begin
                    if (wait_cnt == 4'h1)
                    begin
                        state     <= SCS_DONE;
                        usr_rdata <= bus.rdata;
                    end
                    wait_cnt <= wait_cnt - 4'h1;
                end
                SCS_DONE:
                begin
                    state    <= SCS_IDLE;
                    usr_done <= 1'b1;
                end
                default:
                    state <= SCS_IDLE;
            endcase
        end
    end

    // strobes are low for the whole command phase
    assign bus.mem_rd_n = !(strobe_on && kind == 2'h0);
    assign bus.mem_wr_n = !(strobe_on && kind == 2'h1);
    assign bus.io_rd_n  = !(strobe_on && kind == 2'h2);
    assign bus.io_wr_n  = !(strobe_on && kind == 2'h3);

    // buffer and ROM enables, all active low, registered
    always_ff @(posedge bus.sys_clk)
    begin
        if (bus.sys_rst)
        begin
            upper_buffer_gate <= 1'b1;
            low_byte_rom_oe   <= 1'b1;
            high_byte_rom_oe  <= 1'b1;
            rom_buffer_gate   <= 1'b1;
        end
        else
        begin
            // 16-bit memory select covers the whole 128K video segment, so
            // 8-bit cards cannot live in that region
            upper_buffer_gate <= !((!bus.data_buffer_enable_out && !bus.mem_wr_n
                                    && !bus.byte_high_n && !bus.data_size_sixteen_out)
                                   || (!bus.bios_rom_enable_out && !bus.mem_rd_n
                                       && !bus.byte_high_n && !bus.rom_width_indication)
                                   || (!bus.data_buffer_enable_out && !bus.mem_rd_n
                                       && !bus.byte_high_n && !bus.data_size_sixteen_out
                                       && bus.bios_rom_enable_out));
            low_byte_rom_oe   <= !(!bus.bios_rom_enable_out && !bus.mem_rd_n
                                   && !bus.addr[0]);
            high_byte_rom_oe  <= !((!bus.bios_rom_enable_out && !bus.byte_high_n
                                    && !bus.mem_rd_n && !bus.rom_width_indication)
                                   || (!bus.bios_rom_enable_out && bus.addr[0]
                                       && !bus.mem_rd_n && bus.rom_width_indication));
            rom_buffer_gate   <= !(!bus.bios_rom_enable_out && bus.addr[0]
                                   && !bus.mem_rd_n && bus.rom_width_indication);
        end
    end
endmodule

// >>> bench/scs_chk.sv
`timescale 1ns/10ps
// watches the wires of the first interface
module scs_chk
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  video_memory_data_pins,
    input wire logic [19:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        io_rd_n,
    input wire logic        io_wr_n,
    input wire logic        bios_rom_enable_out,
    input wire logic        card_feedback_out,
    input wire logic        rom_width_indication,
    input wire logic        aux_one_out,
    input wire logic        aux_one_oe,
    input wire logic        aux_two_out,
    input wire logic        aux_two_oe
);
    logic [1:0] age;
    logic       ok;
    logic [7:0] pin;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // cycles since reset release, saturating
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            age <= 2'h0;
        else if (age != 2'h3)
            age <= age + 2'h1;
    end
    // config settled and strap shorthand
    assign ok  = (age == 2'h3);
    assign pin = video_memory_data_pins;
    property p_oe;
        ok |-> aux_one_oe == pin[3] && aux_two_oe == pin[3];
    endproperty
    a_oe: assert property (p_oe) else $error("aux enable off strap");
    property p_width;
        ok |-> rom_width_indication == pin[1];
    endproperty
    a_width: assert property (p_width) else $error("width flag wrong");
    property p_fdbk;
        ok && pin[2] |-> card_feedback_out == pin[1];
    endproperty
    a_fdbk: assert property (p_fdbk) else $error("feedback wrong");
    property p_rom;
        ok && !pin[0] |-> bios_rom_enable_out;
    endproperty
    a_rom: assert property (p_rom) else $error("rom decode not off");
    property p_stat;
        ok && !io_rd_n && addr[15:0] == scs_pkg::STATUS5_ADDR |=> rdata == {~pin[7:4], 4'h0};
    endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    property p_cfg;
        ok && !io_rd_n && addr[15:0] == scs_pkg::ROM_CFG_ADDR |=> rdata == {6'h00, ~pin[1:0]};
    endproperty
    a_cfg: assert property (p_cfg) else $error("rom cfg read wrong");
    property p_unm;
        ok && !io_rd_n && addr[15:0] == 16'h03e3 |=> rdata == 8'h00;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_pulse;
        $fell(io_wr_n) && addr[15:0] == scs_pkg::MISC_ADDR && aux_one_oe
            |=> !aux_one_out ##1 aux_one_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("load pulse wrong");
    property p_two;
        $fell(io_wr_n) && addr[15:0] == scs_pkg::SEC_CTRL_ADDR && aux_two_oe
            |-> ##2 aux_two_out == $past(wdata[1], 2);
    endproperty
    a_two: assert property (p_two) else $error("aux two wrong");
endmodule

// >>> bench/scs_test.sv
`timescale 1ns/10ps
// two device and host pairs: a isa with clock outputs, b channel with clock inputs
module scs_test;
    localparam int REF = 8;
    logic        sys_clk;
    logic        sys_rst;
    logic        start;
    logic [1:0]  kind;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        bh;
    logic [1:0]  osc;
    wire  [1:0]  busy;
    logic [7:0]  rd_a, rd_b, misc_a, misc_b;
    logic [1:0]  sel_a, sel_b;
    logic        isa_a, isa_b, oe_a, oe_b, ref_a, ref_b, ok_a, ok_b;
    logic        rom_a, rom_b, ds_b, pal_a;
    logic        ub_a, lo_b, hi_b, bg_b;
    logic [3:0]  glue;
    int          bad_count, compares, pulses, nref, n0;
    scs_if ifa (.sys_clk(sys_clk), .sys_rst(sys_rst));
    scs_if ifb (.sys_clk(sys_clk), .sys_rst(sys_rst));
    scs_device #(.MEM_KB(1024), .REFRESH_CYC(REF)) scs_device_inst
    (
        .bus(ifa), .dot_clk_sel(sel_a), .bus_is_isa(isa_a), .aux_clk_outputs(oe_a),
        .dram_refresh_req(ref_a), .misc_output_clock_select(misc_a), .mem_size_ok(ok_a)
    );
    scs_host #(.STRAP_LEVELS(8'h5c)) scs_host_inst
    (
        .bus(ifa), .usr_start(start), .usr_kind(kind), .usr_addr(addr), .usr_wdata(wdata),
        .usr_byte_high(bh), .usr_osc(osc), .usr_busy(busy[0]), .usr_done(),
        .usr_rdata(rd_a), .upper_buffer_gate(ub_a), .low_byte_rom_oe(), .high_byte_rom_oe(),
        .rom_buffer_gate()
    );
    scs_device #(.REFRESH_CYC(REF)) scs_device_inst_b
    (
        .bus(ifb), .dot_clk_sel(sel_b), .bus_is_isa(isa_b), .aux_clk_outputs(oe_b),
        .dram_refresh_req(ref_b), .misc_output_clock_select(misc_b), .mem_size_ok(ok_b)
    );
    scs_host #(.STRAP_LEVELS(8'h31)) scs_host_inst_b
    (
        .bus(ifb), .usr_start(start), .usr_kind(kind), .usr_addr(addr), .usr_wdata(wdata),
        .usr_byte_high(bh), .usr_osc(osc), .usr_busy(busy[1]), .usr_done(),
        .usr_rdata(rd_b), .upper_buffer_gate(), .low_byte_rom_oe(lo_b), .high_byte_rom_oe(hi_b),
        .rom_buffer_gate(bg_b)
    );
    scs_chk scs_chk_inst
    (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .video_memory_data_pins(ifa.video_memory_data_pins),
        .addr(ifa.addr), .wdata(ifa.wdata), .rdata(ifa.rdata), .io_rd_n(ifa.io_rd_n),
        .io_wr_n(ifa.io_wr_n), .bios_rom_enable_out(ifa.bios_rom_enable_out),
        .card_feedback_out(ifa.card_feedback_out),
        .rom_width_indication(ifa.rom_width_indication), .aux_one_out(ifa.aux_one_out),
        .aux_one_oe(ifa.aux_one_oe), .aux_two_out(ifa.aux_two_out), .aux_two_oe(ifa.aux_two_oe)
    );
    // free running system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // counts pulses and latches strobes, sampled mid cycle
    always @(negedge sys_clk)
    begin
        if (ifa.aux_one_out === 1'b0) pulses++;
        if (ref_a === 1'b1) nref++;
        if (ref_b === 1'b1) nref++;
        if (ifa.bios_rom_enable_out === 1'b0) rom_a = 1'b1;
        if (ifb.bios_rom_enable_out === 1'b0) rom_b = 1'b1;
        if (ifb.data_size_sixteen_out === 1'b0) ds_b = 1'b1;
        if (ifa.palette_write_strobe === 1'b0) pal_a = 1'b1;
        if (ub_a === 1'b0) glue[3] = 1'b1;
        if (lo_b === 1'b0) glue[2] = 1'b1;
        if (hi_b === 1'b0) glue[1] = 1'b1;
        if (bg_b === 1'b0) glue[0] = 1'b1;
    end
    task automatic print_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask
    // one host transfer on both pairs, bounded wait for both to go idle
    task automatic xfer(input logic [1:0] k, input logic [19:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        start <= 1'b1;
        kind  <= k;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (busy !== 2'b00 && n < 40);
        chk({6'h00, busy}, 8'h00, "transfer stuck");
        @(posedge sys_clk);
    endtask
    task automatic iow(input logic [15:0] a, input logic [7:0] d);
        xfer(2'h3, {4'h0, a}, d);
    endtask
    task automatic ior(input logic [15:0] a);
        xfer(2'h2, {4'h0, a}, 8'h00);
    endtask
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        {sys_rst, start, kind, addr, wdata, bh} = {1'b1, 32'h0};
        osc = 2'b10;
        {rom_a, rom_b, ds_b, pal_a, glue} = 8'h00;
        {bad_count, compares, pulses, nref} = {4{32'h0}};
        do_reset();
        // captured straps, before and after a reset in mid-run
        for (int r = 0; r < 2; r++)
        begin
            ior(scs_pkg::ROM_CFG_ADDR);
            chk(rd_a, 8'h03, "rom cfg a");
            chk(rd_b, 8'h02, "rom cfg b");
            ior(scs_pkg::STATUS5_ADDR);
            chk(rd_a, 8'ha0, "status a");
            chk(rd_b, 8'hc0, "status b");
            ior(16'h03e3);
            chk(rd_a, 8'h00, "unmapped");
            chk({isa_a, oe_a, isa_b, oe_b, 4'h0}, 8'hc0, "bus and clock");
            do_reset();
        end
        // software write must not disturb the captured straps
        iow(scs_pkg::ROM_CFG_ADDR, 8'h00);
        ior(scs_pkg::ROM_CFG_ADDR);
        chk(rd_a, 8'h03, "rom cfg held");
        $display("test straps done");
        // every misc clock pattern
        for (int i = 0; i < 4; i++)
        begin
            iow(scs_pkg::MISC_ADDR, 8'(i * 4));
            chk(misc_b, 8'(i * 4), "misc value b");
            chk(misc_a, 8'(i * 4), "misc value a");
            chk({6'h00, sel_b}, {6'h00, i[1] ? 2'h2 : 2'(i)}, "clock pick");
            chk({6'h00, sel_a}, 8'h00, "forced clock");
        end
        chk(8'(pulses), 8'h04, "load pulses");
        $display("test clock select done");
        // aux pin two and oscillator pins
        for (int v = 0; v < 2; v++)
        begin
            iow(scs_pkg::SEC_CTRL_ADDR, v[0] ? 8'h02 : 8'hfd);
            chk({7'h00, ifa.aux_clock_pin_two}, 8'(v), "aux two");
        end
        chk({6'h00, ifb.aux_clock_pin_two, ifb.aux_clock_pin_one}, 8'h02, "osc pins");
        $display("test aux pins done");
        // bios window read, palette write, refresh rate
        bh <= 1'b1;
        xfer(2'h0, 20'hc0000, 8'h00);
        chk({6'h00, rom_a, rom_b}, 8'h01, "rom enables");
        chk({7'h00, ds_b}, 8'h01, "size sixteen");
        chk({7'h00, ifa.card_feedback_out}, 8'h00, "isa feedback");
        chk({4'h0, glue}, 8'h06, "rom glue");
        xfer(2'h1, 20'ha0000, 8'h00);
        chk({7'h00, glue[3]}, 8'h01, "upper buffer");
        iow(scs_pkg::PAL_LO_ADDR + 16'h0002, 8'h00);
        chk({7'h00, pal_a}, 8'h01, "palette strobe");
        @(posedge sys_clk);
        #1;
        n0 = nref;
        repeat (80) @(posedge sys_clk);
        #1;
        chk(8'(nref - n0), 8'(2 * 80 / REF), "refresh count");
        chk({6'h00, ok_a, ok_b}, 8'h03, "memory size");
        $display("test bus and refresh done");
        print_verdict();
    end
endmodule
